// ==== rtl/coss_defines.vh ====
// Function
// - three outputs 4-6, independent code and form
// - writable source code, nineteen functions
// - reset: code off, form normally open
// - code 2 follows running/stopped state
// - codes 4-6: fault, warning, any alarm
// - code 7: any maintenance reminder pending
// - code 8: channel one temperature ok
// - code 9: channel two temperature ok
// - code 10: temperature-out flag
// - codes 15-16 pass contact inputs 1-2
// - normally closed inverts pass-through inputs
// - code 17 passes contact input three
// - code 18 follows one chosen alarm
// - code 19 follows one chosen reminder
// - contact inputs 1-2 raise detection alarms
`ifndef COSS_DEFINES_VH
`define COSS_DEFINES_VH

`define COSS_ADDR_W       8
`define COSS_OFS_CFG4     8'h00
`define COSS_OFS_CFG5     8'h04
`define COSS_OFS_CFG6     8'h08
`define COSS_OFS_ALSEL    8'h0C
`define COSS_OFS_MTSEL    8'h10
`define COSS_OFS_DICTL    8'h14
`define COSS_OFS_STAT     8'h18

`define COSS_SRC_W        5
`define COSS_SRC_LSB      0
`define COSS_SRC_MSB      4
`define COSS_FORM_BIT     8
`define COSS_SRC_RST      5'h01
`define COSS_FORM_RST     1'b0

`define COSS_SRC_OFF      5'h01
`define COSS_SRC_RUN      5'h02
`define COSS_SRC_MODE     5'h03
`define COSS_SRC_FAULT    5'h04
`define COSS_SRC_WARN     5'h05
`define COSS_SRC_ALARM    5'h06
`define COSS_SRC_MAINT    5'h07
`define COSS_SRC_CH1OK    5'h08
`define COSS_SRC_CH2OK    5'h09
`define COSS_SRC_TOUT     5'h0A
`define COSS_SRC_EXTT     5'h0B
`define COSS_SRC_START    5'h0C
`define COSS_SRC_FREEZE   5'h0D
`define COSS_SRC_WARMUP   5'h0E
`define COSS_SRC_DIN1     5'h0F
`define COSS_SRC_DIN2     5'h10
`define COSS_SRC_DIN3     5'h11
`define COSS_SRC_SELAL    5'h12
`define COSS_SRC_SELMT    5'h13
`define COSS_SRC_LAST     5'h13

`define COSS_ALSEL_W      6
`define COSS_ALSEL_RST    6'h00
`define COSS_MTSEL_W      4
`define COSS_MTSEL_RST    4'h0
`define COSS_DIN1_ALARM   30
`define COSS_DIN2_ALARM   31

`define COSS_DI_EN1_BIT   0
`define COSS_DI_FLT1_BIT  1
`define COSS_DI_EN2_BIT   2
`define COSS_DI_FLT2_BIT  3
`define COSS_DICTL_W      4
`define COSS_DICTL_RST    4'h0

`define COSS_ST_DET_LSB   4
`define COSS_ST_RUN_BIT   8
`define COSS_ST_FLT_BIT   9
`define COSS_ST_WRN_BIT   10
`define COSS_ST_ANY_BIT   11

`endif

// ==== rtl/coss_sel.v ====
`timescale 1ns/1ps
`include "coss_defines.vh"

module coss_sel
(
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire [`COSS_SRC_W-1:0] src_i,
  input  wire                   form_nc_i,
  input  wire [31:0]            src_vec_i,
  output reg                    closed_o
);

  reg active;

  always @*
  begin
    // codes above the table, and off, leave the output inactive
    if (src_i > `COSS_SRC_LAST)
      active = 1'b0;
    else
      active = src_vec_i[src_i];
  end

  // contact closed = active, flipped by normally closed form
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      closed_o <= 1'b0;
    else
      closed_o <= active ^ form_nc_i;
  end

endmodule

// ==== rtl/coss_top.v ====
`timescale 1ns/1ps
`include "coss_defines.vh"

module coss_top
#(
  parameter ALARM_W = 46,
  parameter MAINT_W = 12
)
(
  input  wire                    clk_i,
  input  wire                    rst_i,
  input  wire [`COSS_ADDR_W-1:0] avs_address_i,
  input  wire                    avs_read_i,
  input  wire                    avs_write_i,
  input  wire [3:0]              avs_byteenable_i,
  input  wire [31:0]             avs_writedata_i,
  output reg  [31:0]             avs_readdata_o,
  output reg                     avs_waitrequest_o,
  input  wire                    running_i,
  input  wire                    local_contact_control_mode_i,
  input  wire                    stop_on_fault_alarm_i,
  input  wire                    continue_on_warning_alarm_i,
  input  wire [ALARM_W-1:0]      alarm_i,
  input  wire [MAINT_W-1:0]      maint_i,
  input  wire                    chan1_temperature_ok_i,
  input  wire                    chan2_temperature_ok_i,
  input  wire                    temp_out_i,
  input  wire                    startup_en_i,
  input  wire                    anti_freeze_en_i,
  input  wire                    warm_up_en_i,
  input  wire                    contact_in1_i,
  input  wire                    contact_in2_i,
  input  wire                    contact_in3_i,
  output wire [2:0]              contact_closed_o,
  output reg  [1:0]              din_alarm_o,
  output reg                     din_fault_o,
  output reg                     din_warn_o
);

  localparam NOUT = 3;

  reg  [`COSS_SRC_W-1:0]   src_q [0:NOUT-1];
  reg  [NOUT-1:0]          form_nc_q;
  reg  [`COSS_ALSEL_W-1:0] alsel_q;
  reg  [`COSS_MTSEL_W-1:0] mtsel_q;
  reg  [`COSS_DICTL_W-1:0] dictl_q;
  reg  [1:0]               det_d;
  reg                      det_flt_d;
  reg                      det_wrn_d;

  reg  [ALARM_W-1:0]       alarm_vec;
  reg                      fault_any;
  reg                      warn_any;
  reg                      any_alarm;
  reg                      maint_any;
  reg                      alarm_pick;
  reg                      maint_pick;
  reg  [31:0]              src_vec;

  reg                      req_hit;
  reg  [31:0]              rd_mux;
  wire                     req;
  wire                     commit;

  assign req    = avs_read_i | avs_write_i;
  assign commit = req & ~avs_waitrequest_o;

  // contact input detection alarms, level flags while input is seen
  always @*
  begin
    det_d[0]  = dictl_q[`COSS_DI_EN1_BIT] & contact_in1_i;
    det_d[1]  = dictl_q[`COSS_DI_EN2_BIT] & contact_in2_i;
    det_flt_d = (det_d[0] & dictl_q[`COSS_DI_FLT1_BIT]) |
                (det_d[1] & dictl_q[`COSS_DI_FLT2_BIT]);
    det_wrn_d = (det_d[0] & ~dictl_q[`COSS_DI_FLT1_BIT]) |
                (det_d[1] & ~dictl_q[`COSS_DI_FLT2_BIT]);
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      din_alarm_o <= 2'b00;
      din_fault_o <= 1'b0;
      din_warn_o  <= 1'b0;
    end
    else
    begin
      din_alarm_o <= det_d;
      din_fault_o <= det_flt_d;
      din_warn_o  <= det_wrn_d;
    end
  end

  // detection flags take their alarm slots in the selectable list
  always @*
  begin
    alarm_vec = alarm_i;
    alarm_vec[`COSS_DIN1_ALARM] = alarm_i[`COSS_DIN1_ALARM] |
                                  din_alarm_o[0];
    alarm_vec[`COSS_DIN2_ALARM] = alarm_i[`COSS_DIN2_ALARM] |
                                  din_alarm_o[1];
  end

  always @*
  begin
    fault_any = stop_on_fault_alarm_i | din_fault_o;
    warn_any  = continue_on_warning_alarm_i | din_warn_o;
    any_alarm = (|alarm_vec) | fault_any | warn_any;
    maint_any = |maint_i;
    // an index past the list selects nothing rather than an x
    if (alsel_q < ALARM_W)
      alarm_pick = alarm_vec[alsel_q];
    else
      alarm_pick = 1'b0;
    if (mtsel_q < MAINT_W)
      maint_pick = maint_i[mtsel_q];
    else
      maint_pick = 1'b0;
  end

  // candidate sources indexed by source code
  always @*
  begin
    src_vec = 32'h0000_0000;
    src_vec[`COSS_SRC_OFF]    = 1'b0;
    src_vec[`COSS_SRC_RUN]    = running_i;
    src_vec[`COSS_SRC_MODE]   = local_contact_control_mode_i;
    src_vec[`COSS_SRC_FAULT]  = fault_any;
    src_vec[`COSS_SRC_WARN]   = warn_any;
    src_vec[`COSS_SRC_ALARM]  = any_alarm;
    src_vec[`COSS_SRC_MAINT]  = maint_any;
    src_vec[`COSS_SRC_CH1OK]  = chan1_temperature_ok_i;
    src_vec[`COSS_SRC_CH2OK]  = chan2_temperature_ok_i;
    src_vec[`COSS_SRC_TOUT]   = temp_out_i;
    src_vec[`COSS_SRC_EXTT]   = 1'b0;
    src_vec[`COSS_SRC_START]  = startup_en_i;
    src_vec[`COSS_SRC_FREEZE] = anti_freeze_en_i;
    src_vec[`COSS_SRC_WARMUP] = warm_up_en_i;
    src_vec[`COSS_SRC_DIN1]   = contact_in1_i;
    src_vec[`COSS_SRC_DIN2]   = contact_in2_i;
    src_vec[`COSS_SRC_DIN3]   = contact_in3_i;
    src_vec[`COSS_SRC_SELAL]  = alarm_pick;
    src_vec[`COSS_SRC_SELMT]  = maint_pick;
  end

  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1)
    begin : g_out
      coss_sel u_sel
      (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .src_i     (src_q[g]),
        .form_nc_i (form_nc_q[g]),
        .src_vec_i (src_vec),
        .closed_o  (contact_closed_o[g])
      );
    end
  endgenerate

  // read mux; unmapped offsets read zero
  always @*
  begin
    req_hit = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (avs_address_i)
      `COSS_OFS_CFG4:
      begin
        rd_mux[`COSS_SRC_MSB:`COSS_SRC_LSB] = src_q[0];
        rd_mux[`COSS_FORM_BIT] = form_nc_q[0];
      end
      `COSS_OFS_CFG5:
      begin
        rd_mux[`COSS_SRC_MSB:`COSS_SRC_LSB] = src_q[1];
        rd_mux[`COSS_FORM_BIT] = form_nc_q[1];
      end
      `COSS_OFS_CFG6:
      begin
        rd_mux[`COSS_SRC_MSB:`COSS_SRC_LSB] = src_q[2];
        rd_mux[`COSS_FORM_BIT] = form_nc_q[2];
      end
      `COSS_OFS_ALSEL:
        rd_mux[`COSS_ALSEL_W-1:0] = alsel_q;
      `COSS_OFS_MTSEL:
        rd_mux[`COSS_MTSEL_W-1:0] = mtsel_q;
      `COSS_OFS_DICTL:
        rd_mux[`COSS_DICTL_W-1:0] = dictl_q;
      `COSS_OFS_STAT:
      begin
        rd_mux[NOUT-1:0] = contact_closed_o;
        rd_mux[`COSS_ST_DET_LSB+1:`COSS_ST_DET_LSB] = din_alarm_o;
        rd_mux[`COSS_ST_RUN_BIT] = running_i;
        rd_mux[`COSS_ST_FLT_BIT] = fault_any;
        rd_mux[`COSS_ST_WRN_BIT] = warn_any;
        rd_mux[`COSS_ST_ANY_BIT] = any_alarm;
      end
      default:
        req_hit = 1'b0;
    endcase
  end

  // two-cycle answer: wait drops the cycle after a request shows,
  // the access completes at the edge that sees it low
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else if (req & avs_waitrequest_o)
    begin
      avs_waitrequest_o <= 1'b0;
      if (avs_read_i & req_hit)
        avs_readdata_o <= rd_mux;
      else
        avs_readdata_o <= 32'h0000_0000;
    end
    else
      avs_waitrequest_o <= 1'b1;
  end

  // configuration registers; writes land on the completing edge
  genvar k;
  generate
    for (k = 0; k < NOUT; k = k + 1)
    begin : g_cfg
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          src_q[k]     <= `COSS_SRC_RST;
          form_nc_q[k] <= `COSS_FORM_RST;
        end
        else if (commit & avs_write_i &
                 (avs_address_i == (`COSS_OFS_CFG4 + 8'h04 * k)))
        begin
          if (avs_byteenable_i[0])
            src_q[k] <=
              avs_writedata_i[`COSS_SRC_MSB:`COSS_SRC_LSB];
          if (avs_byteenable_i[1])
            form_nc_q[k] <= avs_writedata_i[`COSS_FORM_BIT];
        end
      end
    end
  endgenerate

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      alsel_q <= `COSS_ALSEL_RST;
      mtsel_q <= `COSS_MTSEL_RST;
      dictl_q <= `COSS_DICTL_RST;
    end
    else if (commit & avs_write_i & avs_byteenable_i[0])
    begin
      case (avs_address_i)
        `COSS_OFS_ALSEL:
          alsel_q <= avs_writedata_i[`COSS_ALSEL_W-1:0];
        `COSS_OFS_MTSEL:
          mtsel_q <= avs_writedata_i[`COSS_MTSEL_W-1:0];
        `COSS_OFS_DICTL:
          dictl_q <= avs_writedata_i[`COSS_DICTL_W-1:0];
        default:
          dictl_q <= dictl_q;
      endcase
    end
  end

endmodule

// ==== test/coss_chk.sv ====
`timescale 1ns/1ps

module coss_chk
(
  input logic        clk_i,
  input logic        rst_i,
  input logic [7:0]  avs_address_i,
  input logic        avs_read_i,
  input logic        avs_write_i,
  input logic [31:0] avs_readdata_o,
  input logic        avs_waitrequest_o,
  input logic [2:0]  contact_closed_o,
  input logic [1:0]  din_alarm_o,
  input logic        din_fault_o,
  input logic        din_warn_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_wait_ans;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("request not answered in one cycle");

  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low longer than one cycle");

  property p_wait_idle;
    !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest dropped without request");

  property p_stat;
    avs_read_i && avs_waitrequest_o && avs_address_i == 8'h18 |=>
      avs_readdata_o[5:0] == {$past(din_alarm_o), 1'b0,
                              $past(contact_closed_o)};
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read does not match outputs");

  property p_unmapped;
    avs_read_i && avs_waitrequest_o && avs_address_i == 8'h1C |=>
      avs_readdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_rd_hold;
    avs_waitrequest_o && !avs_read_i && !avs_write_i |=>
      $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed while idle");

  property p_reset;
    $fell(rst_i) |-> contact_closed_o == 3'b000 && avs_waitrequest_o &&
      din_alarm_o == 2'b00;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not at rest after reset");

  property p_din;
    din_fault_o || din_warn_o |-> din_alarm_o != 2'b00;
  endproperty
  a_din: assert property (p_din)
    else $error("mode flag without detection alarm");
endmodule

bind coss_top coss_chk u_chk
(
  .clk_i             (clk_i),
  .rst_i             (rst_i),
  .avs_address_i     (avs_address_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_readdata_o    (avs_readdata_o),
  .avs_waitrequest_o (avs_waitrequest_o),
  .contact_closed_o  (contact_closed_o),
  .din_alarm_o       (din_alarm_o),
  .din_fault_o       (din_fault_o),
  .din_warn_o        (din_warn_o)
);

// ==== test/coss_relay_sense.sv ====
`timescale 1ns/1ps

// far-side equipment: latches relay state once per clock, so it
// reports one edge behind the contacts
module coss_relay_sense
(
  input  logic       clk_i,
  input  logic [2:0] contact_i,
  output logic [2:0] sensed_o
);
  always @(posedge clk_i)
    sensed_o <= contact_i;
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`include "coss_defines.vh"

module testbench;
  logic        clk_i, rst_i, rd, wr;
  logic [7:0]  adr;
  logic [31:0] wd, q;
  logic [19:0] s;
  logic [3:0]  be;
  wire  [31:0] rdat;
  wire         wait_o, dflt, dwrn;
  wire  [2:0]  cc, seen;
  wire  [1:0]  dal;
  integer      fails, compares, cyc;

  // s bit n raises the source that code n selects, except codes 1 and 11
  coss_top DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .running_i(s[2]), .local_contact_control_mode_i(s[3]),
    .stop_on_fault_alarm_i(s[4]), .continue_on_warning_alarm_i(s[5]),
    .alarm_i({40'h0, s[18], 4'h0, s[6]}),
    .maint_i({8'h0, s[19], 1'b0, s[7], 1'b0}),
    .chan1_temperature_ok_i(s[8]), .chan2_temperature_ok_i(s[9]),
    .temp_out_i(s[10]), .startup_en_i(s[12]), .anti_freeze_en_i(s[13]),
    .warm_up_en_i(s[14]), .contact_in1_i(s[15]), .contact_in2_i(s[16]),
    .contact_in3_i(s[17]), .contact_closed_o(cc), .din_alarm_o(dal),
    .din_fault_o(dflt), .din_warn_o(dwrn));
  coss_relay_sense u_sense (.clk_i(clk_i), .contact_i(cc), .sensed_o(seen));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task stop_test;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails = fails + 1;
      stop_test;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
        fails = fails + 1;
      end
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk_i);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      @(posedge clk_i);
      while (wait_o !== 1'b0)
        @(posedge clk_i);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask

  // write, then let output and sensing register pass
  task cfg(input integer j, input logic [31:0] d);
    begin
      bus(1'b1, 8'(4 * j), d);
      repeat (4) @(posedge clk_i);
    end
  endtask

  task t_reset;
    integer j;
    begin
      chk(32'(seen), 32'h0000_0000);
      for (j = 0; j < 3; j++)
      begin
        bus(1'b0, 8'(4 * j), 32'h0000_0000);
        chk(q, 32'h0000_0001);
      end
      bus(1'b1, 8'h1C, 32'h0000_0013);
      bus(1'b0, 8'h1C, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      // lane 1 only: form changes, code stays off
      be <= 4'h2;
      bus(1'b1, `COSS_OFS_CFG4, 32'h0000_0113);
      be <= 4'hF;
      bus(1'b0, `COSS_OFS_CFG4, 32'h0000_0000);
      chk(q, 32'h0000_0101);
      $display("test reset done");
    end
  endtask

  task run_code(input integer c);
    integer n, v;
    begin
      for (n = 0; n < 2; n++)
        for (v = 0; v < 2; v++)
        begin
          s <= 20'(v) << c;
          cfg(c % 3, 32'(c) | (32'(n) << 8));
          chk(32'(seen[c % 3]), (c == 1 || c == 11) ? n : v ^ n);
        end
    end
  endtask

  task t_codes;
    integer c;
    begin
      bus(1'b1, `COSS_OFS_ALSEL, 32'h0000_0005);
      bus(1'b1, `COSS_OFS_MTSEL, 32'h0000_0003);
      run_code(1);
      run_code(2);
      for (c = 3; c <= 6; c++) run_code(c);
      run_code(7);
      run_code(8);
      run_code(9);
      for (c = 10; c <= 14; c++) run_code(c);
      for (c = 15; c <= 16; c++) run_code(c);
      run_code(17);
      run_code(18);
      run_code(19);
      $display("test codes done");
    end
  endtask

  task t_indep;
    begin
      s <= 20'h0_8004;
      cfg(0, 32'h0000_0002);
      cfg(1, 32'h0000_0102);
      cfg(2, 32'h0000_010F);
      chk(32'(seen), 32'h0000_0001);
      s <= 20'h0_0000;
      repeat (4) @(posedge clk_i);
      chk(32'(seen), 32'h0000_0006);
      bus(1'b0, `COSS_OFS_STAT, 32'h0000_0000);
      chk(q & 32'h0000_0107, 32'h0000_0006);
      $display("test independence done");
    end
  endtask

  task t_din;
    begin
      s <= 20'h0_8000;
      bus(1'b1, `COSS_OFS_ALSEL, 32'h0000_001E);
      bus(1'b1, `COSS_OFS_DICTL, 32'h0000_0003);
      cfg(0, 32'h0000_0004);
      cfg(1, 32'h0000_0012);
      cfg(2, 32'h0000_0005);
      chk({29'h0, seen}, 32'h0000_0003);
      chk({28'h0, dal, dflt, dwrn}, 32'h0000_0006);
      cfg(3, 32'h0000_0000);
      bus(1'b1, `COSS_OFS_DICTL, 32'h0000_0001);
      repeat (4) @(posedge clk_i);
      chk({28'h0, dal, dflt, dwrn}, 32'h0000_0005);
      chk(32'(seen), 32'h0000_0004);
      s <= 20'h0_0000;
      repeat (4) @(posedge clk_i);
      chk({27'h0, dal, seen}, 32'h0000_0000);
      $display("test detection done");
    end
  endtask

  // reset in mid-run must drop a closed contact and the settings
  task t_rst2;
    begin
      cfg(0, 32'h0000_0102);
      chk(32'(seen), 32'h0000_0001);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'(seen), 32'h0000_0000);
      bus(1'b0, `COSS_OFS_CFG4, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      $display("test second reset done");
    end
  endtask

  initial
  begin
    s = 20'h0_0000;
    be = 4'hF;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0000_0000;
    rst_i = 1'b1;
    fails = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_codes;
    t_indep;
    t_din;
    t_rst2;
    stop_test;
  end
endmodule
